// file: logic/otw_regs.svh
// Register offsets, field positions, reset values and timing counts
// Included by the bit engine, the wiper master and the testbench; definitions only
`ifndef OTW_REGS_SVH
`define OTW_REGS_SVH
`define OTW_ADDR_W 8
`define OTW_CTRL_OFS 8'h00
`define OTW_WDATA_OFS 8'h04
`define OTW_STATUS_OFS 8'h08
`define OTW_RDATA_OFS 8'h0C
`define OTW_CTRL_GO 0
`define OTW_CTRL_READ 1
`define OTW_CTRL_PROG 2
`define OTW_CTRL_ASEL 3
`define OTW_CTRL_HOLD 4
`define OTW_CTRL_STOP 5
`define OTW_ST_BUSY 0
`define OTW_ST_HOLD 1
`define OTW_ST_DONE 2
`define OTW_ST_NACK 3
`define OTW_ST_FATAL 4
`define OTW_ST_REFUSED 5
`define OTW_SLAVE_ADDR 6'h16
`define OTW_VAL_FATAL 2'h2
`define OTW_WIPER_RST 6'h00
`define OTW_CLK_PERIOD_NS 10
`define OTW_SCL_PERIOD_NS 10000
`define OTW_QUARTER_CYC ((`OTW_SCL_PERIOD_NS + 4 * `OTW_CLK_PERIOD_NS - 1) / (4 * `OTW_CLK_PERIOD_NS))
`endif

// file: logic/otw_pkg.sv
// Types shared by the wiper master and its bit engine
// No timing or offsets here; those live in the register header
package otw_pkg;
  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_STOP = 2'b01,
    OP_WRITE = 2'b10,
    OP_READ = 2'b11
  } otw_op_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_START = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_ADDR_ACK = 4'b0011,
    ST_INSTR = 4'b0100,
    ST_INSTR_ACK = 4'b0101,
    ST_DATA = 4'b0110,
    ST_DATA_ACK = 4'b0111,
    ST_RD_BYTE = 4'b1000,
    ST_RD_ACK = 4'b1001,
    ST_HOLD = 4'b1010,
    ST_STOP = 4'b1011
  } otw_state_t;
endpackage

// file: logic/otw_bit_if.sv
// Request and answer between the byte sequencer and the bit engine
// Both ends run on the same clock; one request outstanding at a time
`timescale 1ns/10ps
interface otw_bit_if;
  import otw_pkg::*;
  logic req;
  otw_op_t cmd;
  logic txBit;
  logic done;
  logic rxBit;
  modport master(output req, output cmd, output txBit, input done, input rxBit);
  modport engine(input req, input cmd, input txBit, output done, output rxBit);
endinterface

// file: logic/otw_sync.sv
// Two-flop synchroniser, one lane per bit, with a chosen reset value
// Inputs may come from any domain; output is on clk
`timescale 1ns/10ps
module otw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
)(
  input logic clk, // Sampling clock
  input logic rstB, // Asynchronous reset, active low
  input logic [W-1:0] d, // Asynchronous levels
  output logic [W-1:0] q // Synchronised levels
);
  logic [W-1:0] metaReg;
  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
    begin
      metaReg <= INIT;
      q <= INIT;
    end
    else
    begin
      metaReg <= d;
      q <= metaReg;
    end
  end
endmodule

// file: logic/otw_bit_engine.sv
// Bit engine: start, stop and single bit slots on open-drain pins
// Assumes synchronised pin levels and requests only while idle
`timescale 1ns/10ps
`include "otw_regs.svh"
module otw_bit_engine
  import otw_pkg::*;
#(
  parameter int QUARTER_CYC = `OTW_QUARTER_CYC
)(
  input logic clk, // System clock
  input logic rstB, // Synchronised reset, active low
  otw_bit_if.engine bus, // Bit request and answer
  input logic sclLevel, // Synchronised clock pin level
  input logic sdaLevel, // Synchronised data pin level
  output logic sclOe, // High pulls clock low
  output logic sdaOe // High pulls data low
);
  logic busyReg;
  otw_op_t opReg;
  logic txReg;
  logic [1:0] phaseReg;
  logic [15:0] cntReg;
  logic sdaHigh;
  logic sclHigh;
  logic tick;
  // Pin levels per quarter of a slot
  always_comb
  begin
    sdaHigh = txReg;
    sclHigh = phaseReg[0] ^ phaseReg[1];
    unique case (opReg)
      OP_START: sdaHigh = !phaseReg[1];
      OP_STOP:
      begin
        sdaHigh = phaseReg[1];
        sclHigh = (phaseReg != 2'h0);
      end
      OP_WRITE, OP_READ: sdaHigh = txReg;
    endcase
  end
  assign tick = busyReg && (cntReg == 16'(QUARTER_CYC - 1));
  // Quarter timer, kept at zero while a slave stretches the clock
  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
      cntReg <= 16'h0000;
    else if (!busyReg || tick || (sclHigh && !sclLevel))
      cntReg <= 16'h0000;
    else
      cntReg <= cntReg + 16'h0001;
  end
  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
    begin
      busyReg <= 1'b0;
      opReg <= OP_STOP;
      txReg <= 1'b1;
      phaseReg <= 2'h0;
      bus.done <= 1'b0;
      bus.rxBit <= 1'b1;
    end
    else
    begin
      bus.done <= tick && (phaseReg == 2'h3);
      if (!busyReg && bus.req)
      begin
        busyReg <= 1'b1;
        opReg <= bus.cmd;
        txReg <= (bus.cmd == OP_READ) ? 1'b1 : bus.txBit;
        phaseReg <= 2'h0;
      end
      else if (tick)
      begin
        phaseReg <= phaseReg + 2'h1;
        if (phaseReg == 2'h3)
          busyReg <= 1'b0;
      end
      // Sample data late in the high half
      if (tick && (phaseReg == 2'h2))
        bus.rxBit <= sdaLevel;
    end
  end
  // data bits move only with clock low; start and stop move data with clock high
  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
    begin
      sclOe <= 1'b0;
      sdaOe <= 1'b0;
    end
    else if (busyReg)
    begin
      sclOe <= !sclHigh;
      sdaOe <= !sdaHigh;
    end
  end
  chk_start_edge: assert property (
    @(posedge clk) disable iff (!rstB)
    (opReg == OP_START && $rose(sdaOe)) |-> !sclOe)
    else $error("start: data fell while clock was low");
  chk_stop_edge: assert property (
    @(posedge clk) disable iff (!rstB)
    (opReg == OP_STOP && $fell(sdaOe)) |-> !sclOe)
    else $error("stop: data rose while clock was low");
  chk_sda_steady: assert property (
    @(posedge clk) disable iff (!rstB)
    (opReg inside {OP_WRITE, OP_READ} && !sclOe && !$past(sclOe)) |-> $stable(sdaOe))
    else $error("data changed while clock was high");
endmodule

// file: logic/otw_wiper_master.sv
// Two-wire master for a one-time-programmable wiper, with APB registers
// Assumes pulled-up open-drain pins; APB master on the same clock
`timescale 1ns/10ps
`include "otw_regs.svh"
module otw_wiper_master
  import otw_pkg::*;
#(
  parameter int QUARTER_CYC = `OTW_QUARTER_CYC
)(
  input logic clk, // System clock, 100 MHz
  input logic rst_b, // Asynchronous reset, active low
  input logic psel, // APB select
  input logic penable, // APB access phase
  input logic pwrite, // APB direction, high writes
  input logic [`OTW_ADDR_W-1:0] paddr, // APB byte address
  input logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input logic sclIn, // Clock pin level
  output logic sclOut, // Clock pin drive value, always low
  output logic sclOe, // Clock pin pulled low when high
  input logic sdaIn, // Data pin level
  output logic sdaOut, // Data pin drive value, always low
  output logic sdaOe // Data pin pulled low when high
);
  logic rstB;
  logic [1:0] pinLevel;
  otw_state_t stateReg;
  logic [7:0] shReg, rdataReg;
  logic [2:0] bitCnt;
  logic pendReg, readSelReg, progReg, addrSelReg, holdReg;
  logic [5:0] wiperReg;
  logic fatalReg, doneFlag, nackFlag, refusedFlag;
  logic [31:0] readMux;
  logic addrHit, setupPhase, wrAcc, ctrlWr, statWr;
  logic goReq, stopReq, progBlocked, startOk, opDone;
  otw_bit_if bus();
  otw_sync #(.W(1), .INIT(1'b0)) u_rst_sync (
    .clk(clk),
    .rstB(rst_b),
    .d(1'b1),
    .q(rstB)
  );
  otw_sync #(.W(2), .INIT(2'b11)) u_pin_sync (
    .clk(clk),
    .rstB(rstB),
    .d({sclIn, sdaIn}),
    .q(pinLevel)
  );
  otw_bit_engine #(.QUARTER_CYC(QUARTER_CYC)) u_engine (
    .clk(clk),
    .rstB(rstB),
    .bus(bus),
    .sclLevel(pinLevel[1]),
    .sdaLevel(pinLevel[0]),
    .sclOe(sclOe),
    .sdaOe(sdaOe)
  );
  assign setupPhase = psel && !penable;
  assign wrAcc = psel && penable && pwrite && pready;
  assign addrHit = (paddr == `OTW_CTRL_OFS) || (paddr == `OTW_WDATA_OFS) ||
    (paddr == `OTW_STATUS_OFS) || (paddr == `OTW_RDATA_OFS);
  assign ctrlWr = wrAcc && (paddr == `OTW_CTRL_OFS);
  assign statWr = wrAcc && (paddr == `OTW_STATUS_OFS);
  assign goReq = ctrlWr && pwdata[`OTW_CTRL_GO];
  assign stopReq = ctrlWr && pwdata[`OTW_CTRL_STOP];
  // no programming after a fatal report
  assign progBlocked = fatalReg && pwdata[`OTW_CTRL_PROG] && !pwdata[`OTW_CTRL_READ];
  assign startOk = (stateReg == ST_IDLE) && goReq && !progBlocked;
  assign opDone = bus.done;

  always_comb
  begin
    readMux = 32'h00000000;
    if (paddr == `OTW_CTRL_OFS)
    begin
      readMux[`OTW_CTRL_READ] = readSelReg;
      readMux[`OTW_CTRL_PROG] = progReg;
      readMux[`OTW_CTRL_ASEL] = addrSelReg;
      readMux[`OTW_CTRL_HOLD] = holdReg;
    end
    else if (paddr == `OTW_WDATA_OFS)
      readMux[5:0] = wiperReg;
    else if (paddr == `OTW_STATUS_OFS)
    begin
      readMux[`OTW_ST_BUSY] = (stateReg != ST_IDLE);
      readMux[`OTW_ST_HOLD] = (stateReg == ST_HOLD);
      readMux[`OTW_ST_DONE] = doneFlag;
      readMux[`OTW_ST_NACK] = nackFlag;
      readMux[`OTW_ST_FATAL] = fatalReg;
      readMux[`OTW_ST_REFUSED] = refusedFlag;
    end
    else if (paddr == `OTW_RDATA_OFS)
      readMux[7:0] = rdataReg;
  end

  // Zero-wait slave: answer in the access phase
  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end
    else
    begin
      // Open-drain pins only ever drive low
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      pready <= setupPhase;
      pslverr <= setupPhase && !addrHit;
      if (setupPhase && !pwrite)
        prdata <= readMux;
    end
  end

  // Transfer settings; frozen while a transfer runs, except the hold bit in the hold state
  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
    begin
      readSelReg <= 1'b0;
      progReg <= 1'b0;
      addrSelReg <= 1'b0;
      holdReg <= 1'b0;
    end
    else if (ctrlWr && (stateReg == ST_IDLE))
    begin
      readSelReg <= pwdata[`OTW_CTRL_READ];
      progReg <= pwdata[`OTW_CTRL_PROG];
      addrSelReg <= pwdata[`OTW_CTRL_ASEL];
      holdReg <= pwdata[`OTW_CTRL_HOLD] && !pwdata[`OTW_CTRL_STOP];
    end
    else if (ctrlWr && (stateReg == ST_HOLD))
      holdReg <= pwdata[`OTW_CTRL_HOLD] && !pwdata[`OTW_CTRL_STOP];
  end

  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
      wiperReg <= `OTW_WIPER_RST;
    else if (wrAcc && (paddr == `OTW_WDATA_OFS))
      wiperReg <= pwdata[5:0];
  end

  // One bit-engine request per slot: start, stop or a single bit
  always_comb
  begin
    bus.req = !pendReg && (stateReg != ST_IDLE) && (stateReg != ST_HOLD);
    bus.cmd = OP_WRITE;
    bus.txBit = shReg[7];
    unique case (stateReg)
      ST_START: bus.cmd = OP_START;
      ST_STOP: bus.cmd = OP_STOP;
      ST_ADDR_ACK, ST_INSTR_ACK, ST_DATA_ACK, ST_RD_BYTE: bus.cmd = OP_READ;
      // acknowledge only to continue, else not-acknowledge
      ST_RD_ACK: bus.txBit = !holdReg;
      default: bus.cmd = OP_WRITE;
    endcase
  end

  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
      pendReg <= 1'b0;
    else if (bus.req)
      pendReg <= 1'b1;
    else if (opDone)
      pendReg <= 1'b0;
  end

  // Byte sequencer
  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
    begin
      stateReg <= ST_IDLE;
      shReg <= 8'h00;
      bitCnt <= 3'h7;
    end
    else
    begin
      unique case (stateReg)
        ST_IDLE:
          if (startOk)
            stateReg <= ST_START;
        ST_START:
          if (opDone)
          begin
            shReg <= {`OTW_SLAVE_ADDR, addrSelReg, readSelReg};
            bitCnt <= 3'h7;
            stateReg <= ST_ADDR;
          end
        ST_ADDR, ST_INSTR, ST_DATA:
          if (opDone)
          begin
            shReg <= {shReg[6:0], 1'b0};
            bitCnt <= bitCnt - 3'h1;
            if (bitCnt == 3'h0)
              stateReg <= otw_state_t'(stateReg + 4'h1);
          end
        ST_ADDR_ACK:
          if (opDone)
          begin
            bitCnt <= 3'h7;
            if (bus.rxBit)
              stateReg <= ST_STOP;
            // read goes straight to the data byte
            else if (readSelReg)
              stateReg <= ST_RD_BYTE;
            else
            begin
              // instruction byte with programming bit on top
              shReg <= {progReg, 7'h00};
              stateReg <= ST_INSTR;
            end
          end
        ST_INSTR_ACK:
          if (opDone)
          begin
            // two spare bits above the wiper code
            shReg <= {2'b00, wiperReg};
            bitCnt <= 3'h7;
            stateReg <= bus.rxBit ? ST_STOP : ST_DATA;
          end
        // release data after the last acknowledge
        ST_DATA_ACK:
          if (opDone)
            stateReg <= (!bus.rxBit && holdReg) ? ST_HOLD : ST_STOP;
        ST_RD_BYTE:
          if (opDone)
          begin
            shReg <= {shReg[6:0], bus.rxBit};
            bitCnt <= bitCnt - 3'h1;
            if (bitCnt == 3'h0)
              stateReg <= ST_RD_ACK;
          end
        ST_RD_ACK:
          if (opDone)
            stateReg <= holdReg ? ST_HOLD : ST_STOP;
        ST_HOLD:
          if (goReq || stopReq)
          begin
            bitCnt <= 3'h7;
            shReg <= {2'b00, wiperReg};
            if (readSelReg)
              stateReg <= ST_RD_BYTE;
            else
              stateReg <= goReq ? ST_DATA : ST_STOP;
          end
        ST_STOP:
          if (opDone)
            stateReg <= ST_IDLE;
        default: stateReg <= ST_IDLE;
      endcase
    end
  end

  // Read byte capture and fatal latch
  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
    begin
      rdataReg <= 8'h00;
      fatalReg <= 1'b0;
    end
    else if ((stateReg == ST_RD_BYTE) && opDone && (bitCnt == 3'h0))
    begin
      rdataReg <= {shReg[6:0], bus.rxBit};
      if (shReg[6:5] == `OTW_VAL_FATAL)
        fatalReg <= 1'b1;
    end
  end

  // Sticky flags, write one to clear, set wins
  always_ff @(posedge clk or negedge rstB)
  begin
    if (!rstB)
    begin
      doneFlag <= 1'b0;
      nackFlag <= 1'b0;
      refusedFlag <= 1'b0;
    end
    else
    begin
      doneFlag <= ((stateReg == ST_STOP) && opDone) ||
        (doneFlag && !(statWr && pwdata[`OTW_ST_DONE]));
      nackFlag <= ((stateReg inside {ST_ADDR_ACK, ST_INSTR_ACK, ST_DATA_ACK}) &&
        opDone && bus.rxBit) || (nackFlag && !(statWr && pwdata[`OTW_ST_NACK]));
      refusedFlag <= ((stateReg == ST_IDLE) && goReq && progBlocked) ||
        (refusedFlag && !(statWr && pwdata[`OTW_ST_REFUSED]));
    end
  end

  sequence sStartDone;
    (stateReg == ST_START) && opDone;
  endsequence
  sequence sAddrAcked;
    (stateReg == ST_ADDR_ACK) && opDone && !bus.rxBit;
  endsequence
  chk_addr_byte: assert property (
    @(posedge clk) disable iff (!rstB)
    sStartDone |=> (shReg == {`OTW_SLAVE_ADDR, addrSelReg, readSelReg}) && (bitCnt == 3'h7))
    else $error("address byte loaded wrongly");
  chk_instr_byte: assert property (
    @(posedge clk) disable iff (!rstB)
    (sAddrAcked and !readSelReg) |=> (stateReg == ST_INSTR) && (shReg == {progReg, 7'h00}))
    else $error("instruction byte not sent after address");
  chk_read_noinstr: assert property (
    @(posedge clk) disable iff (!rstB)
    (sAddrAcked and readSelReg) |=> (stateReg == ST_RD_BYTE) ##1 (stateReg == ST_RD_BYTE))
    else $error("read did not go straight to data");
  chk_data_spare: assert property (
    @(posedge clk) disable iff (!rstB)
    $rose(stateReg == ST_DATA) |-> (shReg == {2'b00, wiperReg}))
    else $error("data byte spare bits or code wrong");
  chk_write_stop: assert property (
    @(posedge clk) disable iff (!rstB)
    ((stateReg == ST_DATA_ACK) && opDone && !holdReg) |=> (stateReg == ST_STOP) && bus.req)
    else $error("write did not stop after last acknowledge");
  chk_read_nack: assert property (
    @(posedge clk) disable iff (!rstB)
    ((stateReg == ST_RD_ACK) && bus.req && !holdReg) |-> bus.txBit ##1 pendReg)
    else $error("last read byte was acknowledged");
  chk_fatal_block: assert property (
    @(posedge clk) disable iff (!rstB)
    ((stateReg == ST_IDLE) && goReq && progBlocked) |=> (stateReg == ST_IDLE) && refusedFlag)
    else $error("programming started after fatal report");
  chk_hold_instr: assert property (
    @(posedge clk) disable iff (!rstB)
    (stateReg == ST_HOLD) |=> (stateReg != ST_INSTR) && (stateReg != ST_START))
    else $error("continued write resent instruction");
  chk_apb_ready: assert property (
    @(posedge clk) disable iff (!rstB)
    setupPhase |=> pready ##1 !pready)
    else $error("APB ready not a single access cycle");
endmodule

// file: verification/otw_dev_model.sv
// Behavioural one-time-programmable wiper device on the two-wire bus
// Assumes pulled-up wires; pulls data low only through sdaPull
`timescale 1ns/10ps
module otw_dev_model #(
  parameter logic ASEL_PIN = 1'b0
)(
  input wire logic scl, // Clock wire
  input wire logic sda, // Data wire
  input wire logic present, // Low keeps device off the bus
  input wire logic fuseFail, // High makes fusing fail
  output logic sdaPull, // High pulls data low
  output logic [5:0] wiperCode // Wiper position
);
  logic [7:0] sh, rdSh;
  logic [1:0] valBits;
  logic act, sel, rd, snd, progBit, fused, mAck;
  int cnt, idx;
  initial
  begin
    sdaPull = 1'b0;
    wiperCode = 6'h20;
    valBits = 2'h0;
    fused = 1'b0;
    act = 1'b0;
    progBit = 1'b0;
  end
  always @(sda)
    if (scl === 1'b1)
    begin
      act = !sda;
      cnt = 0;
      idx = 0;
      sel = 1'b0;
      rd = 1'b0;
      snd = 1'b0;
      mAck = 1'b0;
      sdaPull = 1'b0;
    end
  always @(posedge scl)
    if (act)
    begin
      if (cnt < 8)
        sh = {sh[6:0], sda};
      else
        mAck = !sda;
      cnt = cnt + 1;
    end
  always @(negedge scl)
    if (act)
    begin
      if (cnt == 8 && idx == 0)
      begin
        sel = present && sh[7:2] == 6'h16 && sh[1] == ASEL_PIN;
        rd = sh[0];
      end
      if (cnt == 8 && idx == 1 && sel && !rd)
        progBit = sh[7];
      if (cnt == 8 && idx > 1 && sel && !rd && !fused)
      begin
        wiperCode = sh[5:0];
        fused = progBit;
        if (progBit)
          valBits = fuseFail ? 2'h2 : 2'h3;
      end
      if (cnt == 9)
      begin
        snd = sel && rd && mAck;
        cnt = 0;
        idx = idx + 1;
        rdSh = {valBits, wiperCode};
      end
      // ack and read bits, clock low
      sdaPull = (cnt == 8) ? sel && !(rd && idx > 0) : snd && cnt < 8 && !rdSh[7 - cnt];
    end
endmodule

// file: verification/testbench.sv
// Self-checking bench for the wiper master, two device models on one bus
// APB driven from clk; both wires pulled up
`timescale 1ns/10ps
`include "otw_regs.svh"
module testbench;
  localparam logic [31:0] GO = 32'h1 << `OTW_CTRL_GO;
  localparam logic [31:0] RD = 32'h1 << `OTW_CTRL_READ;
  localparam logic [31:0] PG = 32'h1 << `OTW_CTRL_PROG;
  localparam logic [31:0] AS = 32'h1 << `OTW_CTRL_ASEL;
  localparam logic [31:0] HD = 32'h1 << `OTW_CTRL_HOLD;
  localparam logic [31:0] SP = 32'h1 << `OTW_CTRL_STOP;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, errv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic sclOe, sdaOe, sclW, sdaW, pullA, pullB, presB, failB, sclO, sdaO;
  logic [5:0] wipA, wipB;
  int nMismatch, checkCount, sclFalls;
  assign sclW = !sclOe;
  assign sdaW = !(sdaOe | pullA | pullB);
  always #5 clk = !clk;
  always @(negedge sclW)
    sclFalls++;
  otw_wiper_master #(.QUARTER_CYC(2)) i_otw_wiper_master (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclIn(sclW), .sclOut(sclO), .sclOe(sclOe), .sdaIn(sdaW),
    .sdaOut(sdaO), .sdaOe(sdaOe)
  );
  otw_dev_model #(.ASEL_PIN(1'b1)) devA (
    .scl(sclW), .sda(sdaW), .present(1'b1), .fuseFail(1'b0), .sdaPull(pullA),
    .wiperCode(wipA)
  );
  otw_dev_model #(.ASEL_PIN(1'b0)) devB (
    .scl(sclW), .sda(sdaW), .present(presB), .fuseFail(failB), .sdaPull(pullB),
    .wiperCode(wipB)
  );
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic waitSt(input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      apb(`OTW_STATUS_OFS, 1'b0, 32'h0);
      n++;
    end
    while (rdv[b] !== v && n < 500);
    check("status bit", {31'h0, v}, {31'h0, rdv[b]});
  endtask
  task automatic xfer(input logic [31:0] ctl, input int b);
    // A control write while busy outside the hold state is ignored, so let the last stop finish
    waitSt(`OTW_ST_BUSY, 1'b0);
    apb(`OTW_STATUS_OFS, 1'b1, 32'h2C);
    apb(`OTW_CTRL_OFS, 1'b1, ctl | GO);
    waitSt(b, 1'b1);
  endtask
  task automatic readDev(input logic [31:0] ctl, input logic [7:0] exp);
    xfer(ctl | RD, `OTW_ST_DONE);
    apb(`OTW_RDATA_OFS, 1'b0, 32'h0);
    check("read byte", {24'h0, exp}, rdv);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 4; i++)
    begin
      apb(8'(i * 4), 1'b0, 32'h0);
      check("reset value", 32'h0, rdv);
      check("slave error", 32'h0, {31'h0, errv});
    end
    apb(8'h10, 1'b1, 32'h1);
    check("unmapped error", 32'h1, {31'h0, errv});
    apb(`OTW_RDATA_OFS, 1'b1, 32'hFF);
    apb(`OTW_RDATA_OFS, 1'b0, 32'h0);
    check("read only", 32'h0, rdv);
    check("pin drive values", 32'h0, {30'h0, sclO, sdaO});
    $display("test reset done");
  endtask
  task automatic t_write;
    readDev(AS, 8'h20);
    presB <= 1'b0;
    xfer(32'h0, `OTW_ST_NACK);
    presB <= 1'b1;
    apb(`OTW_WDATA_OFS, 1'b1, 32'h15);
    xfer(AS, `OTW_ST_DONE);
    check("wiper a", 32'h15, {26'h0, wipA});
    check("wiper b", 32'h20, {26'h0, wipB});
    $display("test write done");
  endtask
  task automatic t_hold;
    apb(`OTW_WDATA_OFS, 1'b1, 32'h0A);
    xfer(AS | HD, `OTW_ST_HOLD);
    apb(`OTW_CTRL_OFS, 1'b0, 32'h0);
    check("control readback", AS | HD, rdv);
    apb(`OTW_WDATA_OFS, 1'b1, 32'h33);
    apb(`OTW_CTRL_OFS, 1'b1, GO | HD);
    waitSt(`OTW_ST_HOLD, 1'b0);
    waitSt(`OTW_ST_HOLD, 1'b1);
    check("wiper a", 32'h33, {26'h0, wipA});
    apb(`OTW_CTRL_OFS, 1'b1, SP);
    waitSt(`OTW_ST_DONE, 1'b1);
    xfer(RD | AS | HD, `OTW_ST_HOLD);
    apb(`OTW_RDATA_OFS, 1'b0, 32'h0);
    check("first held read", 32'h33, rdv);
    apb(`OTW_CTRL_OFS, 1'b1, GO | HD);
    waitSt(`OTW_ST_HOLD, 1'b0);
    waitSt(`OTW_ST_HOLD, 1'b1);
    apb(`OTW_CTRL_OFS, 1'b1, SP);
    waitSt(`OTW_ST_DONE, 1'b1);
    apb(`OTW_RDATA_OFS, 1'b0, 32'h0);
    check("repeat read", 32'h33, rdv);
    $display("test hold done");
  endtask
  task automatic t_prog;
    apb(`OTW_WDATA_OFS, 1'b1, 32'h2A);
    xfer(AS | PG, `OTW_ST_DONE);
    readDev(AS, 8'hEA);
    apb(`OTW_WDATA_OFS, 1'b1, 32'h01);
    xfer(AS, `OTW_ST_DONE);
    check("fused wiper", 32'h2A, {26'h0, wipA});
    failB <= 1'b1;
    apb(`OTW_WDATA_OFS, 1'b1, 32'h11);
    xfer(PG, `OTW_ST_DONE);
    readDev(32'h0, 8'h91);
    waitSt(`OTW_ST_FATAL, 1'b1);
    sclFalls = 0;
    xfer(PG, `OTW_ST_REFUSED);
    check("no bus activity", 32'h0, sclFalls);
    check("pin drive values", 32'h0, {30'h0, sclO, sdaO});
    $display("test program done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #500000;
    nMismatch++;
    tally_and_finish;
  end
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    failB = 1'b0;
    presB = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_write;
    t_hold;
    t_prog;
    tally_and_finish;
  end
endmodule
